// ---- rtl/sysctl_pkg.sv ----
// constants, state encoding and register map of the reset, wakeup and clock divider block
package sysctl_pkg;

  localparam logic [31:0] RATIO_ADDR = 32'he01fc100;
  localparam logic [31:0] CAUSE_ADDR = 32'he01fc180;

  localparam int POR_BIT = 0;
  localparam int EXT_BIT = 1;
  localparam int WDT_BIT = 2;
  localparam int BOD_BIT = 3;
  localparam int FLAG_W  = 4;

  localparam logic [FLAG_W-1:0] CAUSE_RESET = 4'h1;
  localparam logic [1:0]        RATIO_RESET = 2'h0;

  localparam logic [1:0] RATIO_QUARTER  = 2'h0;
  localparam logic [1:0] RATIO_FULL     = 2'h1;
  localparam logic [1:0] RATIO_HALF     = 2'h2;
  localparam logic [1:0] RATIO_RESERVED = 2'h3;

  // sync vector layout
  localparam int SYN_EXT_N   = 0;
  localparam int SYN_BOD_IRQ = 1;
  localparam int SYN_BOD_RST = 2;
  localparam int SYN_OSC     = 3;
  localparam int SYN_PINS    = 4;
  // idle levels of the control stages: reset pin high, the rest low
  localparam logic [SYN_PINS-1:0] SYNC_CTRL_IDLE = 4'h1;

  localparam int WAKE_CLOCKS = 4096;
  localparam int WAKE_CNT_W  = 13;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_WAIT_OSC,
    ST_COUNT,
    ST_INIT,
    ST_WAIT_PIN,
    ST_RUN,
    ST_SLEEP
  } wake_state_t;

endpackage : sysctl_pkg

// ---- rtl/reset_wakeup_clock_divider.sv ----
// reset cause flags, wakeup timer, peripheral clock enable and brown-out request
module reset_wakeup_clock_divider #(
  parameter int CHANNELS    = 4,
  parameter int PINS_PER_CH = 2,
  parameter int WAKE_CLOCKS = sysctl_pkg::WAKE_CLOCKS
) (
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic                              ext_reset_pin_n,
  input  wire logic                              brownout_below_2v9,
  input  wire logic                              brownout_below_2v6,
  input  wire logic                              osc_detected,
  input  wire logic [CHANNELS*PINS_PER_CH-1:0]   ext_irq_pins,
  input  wire logic [CHANNELS-1:0]               ext_irq_level_mode,
  input  wire logic [CHANNELS-1:0]               ext_irq_polarity,
  input  wire logic [CHANNELS-1:0]               ext_irq_wake_enable,
  input  wire logic [CHANNELS-1:0]               ext_irq_clear,
  input  wire logic                              brownout_wake_enable,
  input  wire logic                              watchdog_timeout,
  input  wire logic                              watchdog_reset_enable,
  input  wire logic                              power_down_request,
  input  wire logic                              idle_mode,
  input  wire logic                              pll_running,
  input  wire logic                              init_done,
  input  wire logic [31:0]                       reg_addr,
  input  wire logic                              reg_write,
  input  wire logic                              reg_read,
  input  wire logic [7:0]                        reg_wdata,
  output logic [7:0]                             reg_rdata,
  output logic                                   cpu_release,
  output logic                                   chip_reset_hold,
  output logic                                   init_start,
  output logic                                   peripheral_clock_enable,
  output logic                                   pll_keep_on,
  output logic                                   brownout_irq,
  output logic [CHANNELS-1:0]                    ext_irq_req,
  output logic [sysctl_pkg::FLAG_W-1:0]          reset_cause_flags
);
  import sysctl_pkg::*;

  localparam int NSYNC = SYN_PINS + CHANNELS * PINS_PER_CH;
  localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CNT_W'(WAKE_CLOCKS - 1);
  // stages start at idle so power-on alone never looks like a pin reset;
  // pins idle high, so an active-high level channel may flag once after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = {{(CHANNELS * PINS_PER_CH){1'b1}}, SYNC_CTRL_IDLE};

  typedef struct packed {
    logic [NSYNC-1:0]      s1;
    logic [NSYNC-1:0]      s2;
    logic [NSYNC-1:0]      s3;
    logic [NSYNC-1:0]      filt;
    logic [FLAG_W-1:0]     flags;
    logic [1:0]            ratio;
    logic [1:0]            active_ratio;
    logic [1:0]            div_cnt;
    logic                  pclk_en;
    wake_state_t           state;
    logic [WAKE_CNT_W-1:0] cnt;
    logic [CHANNELS-1:0]   irq_flags;
    logic [CHANNELS-1:0]   irq_req;
    logic                  bod_irq;
    logic                  release_cpu;
    logic                  init_go;
    logic                  reset_hold;
    logic                  pll_keep;
    logic                  prev_idle;
    logic [7:0]            rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // period of 4, 1 or 2 clocks
  // last count of one peripheral period for a ratio code
  function automatic logic [1:0] period_last(input logic [1:0] code);
    unique case (code)
      RATIO_FULL: period_last = 2'h0;
      RATIO_HALF: period_last = 2'h1;
      default:    period_last = 2'h3;
    endcase
  endfunction : period_last

  // pin level active for the chosen polarity
  function automatic logic pin_active(input logic level, input logic pol);
    pin_active = (level == pol);
  endfunction : pin_active

  logic                ext_active;
  logic                bod_rst;
  logic                wdt_event;
  logic                any_reset;
  logic                wake_event;
  logic                ratio_wr;
  logic                cause_wr;
  logic [CHANNELS-1:0] chan_now;
  logic [CHANNELS-1:0] chan_before;
  logic [CHANNELS-1:0] chan_event;

  always_comb begin
    next_s = s;

    // three stage sampling, value taken once stages two and three agree
    next_s.s1 = {ext_irq_pins, osc_detected, brownout_below_2v6,
                 brownout_below_2v9, ext_reset_pin_n};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < NSYNC; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.filt[i] = s.s3[i];
      end
    end

    ext_active = ~s.filt[SYN_EXT_N];
    bod_rst    = s.filt[SYN_BOD_RST];
    wdt_event  = watchdog_timeout & watchdog_reset_enable;
    any_reset  = ext_active | bod_rst | wdt_event;
    ratio_wr   = reg_write && (reg_addr == RATIO_ADDR);
    cause_wr   = reg_write && (reg_addr == CAUSE_ADDR);

    // level mode ORs the pins, edge mode watches the first pin
    for (int c = 0; c < CHANNELS; c++) begin
      chan_now[c]    = 1'b0;
      chan_before[c] = pin_active(s.filt[SYN_PINS + c * PINS_PER_CH],
                                  ext_irq_polarity[c]);
      if (ext_irq_level_mode[c]) begin
        for (int p = 0; p < PINS_PER_CH; p++) begin
          chan_now[c] = chan_now[c] |
                        pin_active(s.filt[SYN_PINS + c * PINS_PER_CH + p],
                                   ext_irq_polarity[c]);
        end
        chan_event[c] = chan_now[c];
      end else begin
        chan_now[c]   = pin_active(next_s.filt[SYN_PINS + c * PINS_PER_CH],
                                   ext_irq_polarity[c]);
        chan_event[c] = chan_now[c] & ~chan_before[c];
      end
    end

    // enabled channel event or brown-out wakes from power down
    wake_event = |(chan_event & ext_irq_wake_enable) |
                 (brownout_wake_enable & s.filt[SYN_BOD_IRQ]);

    // flag set wins over software clear
    next_s.irq_flags = (s.irq_flags & ~ext_irq_clear) | chan_event;

    if (cause_wr) begin
      next_s.flags = s.flags & ~reg_wdata[FLAG_W-1:0];
    end
    // external pin flag, clears watchdog flag
    if (ext_active) begin
      next_s.flags[WDT_BIT] = 1'b0;
      next_s.flags[EXT_BIT] = 1'b1;
    end
    if (bod_rst) begin
      next_s.flags[WDT_BIT] = 1'b0;
      next_s.flags[BOD_BIT] = 1'b1;
    end
    // watchdog flag only with reset enabled
    if (wdt_event) begin
      next_s.flags[WDT_BIT] = 1'b1;
    end

    // reserved code keeps the previous ratio
    if (ratio_wr && (reg_wdata[1:0] != RATIO_RESERVED)) begin
      next_s.ratio = reg_wdata[1:0];
    end

    // new ratio taken only at a period boundary
    if (s.div_cnt == period_last(s.active_ratio)) begin
      next_s.div_cnt      = 2'h0;
      next_s.active_ratio = s.ratio;
      next_s.pclk_en      = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt + 2'h1;
      next_s.pclk_en = 1'b0;
    end

    // latch PLL state at idle entry
    next_s.prev_idle = idle_mode;
    if (idle_mode && s.prev_idle) begin
      next_s.pll_keep = s.pll_keep;
    end else begin
      next_s.pll_keep = pll_running;
    end

    // any reset restarts the wakeup sequence
    if (any_reset) begin
      next_s.state = ST_HOLD;
      next_s.cnt   = '0;
    end else begin
      unique case (s.state)
        ST_HOLD: begin
          next_s.state = ST_WAIT_OSC;
        end
        ST_WAIT_OSC: begin
          next_s.cnt = '0;
          if (s.filt[SYN_OSC]) begin
            next_s.state = ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (s.cnt == WAKE_LAST) begin
            next_s.state = ST_INIT;
          end else begin
            next_s.cnt = s.cnt + WAKE_CNT_W'(1);
          end
        end
        ST_INIT: begin
          if (init_done) begin
            next_s.state = ST_WAIT_PIN;
          end
        end
        ST_WAIT_PIN: begin
          if (!ext_active) begin
            next_s.state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (power_down_request) begin
            next_s.state = ST_SLEEP;
          end
        end
        // power-down exit runs the timer again
        ST_SLEEP: begin
          if (wake_event) begin
            next_s.state = ST_WAIT_OSC;
          end
        end
        // unused encoding falls back to a full restart
        default: begin
          next_s.state = ST_HOLD;
        end
      endcase
    end

    next_s.release_cpu = (next_s.state == ST_RUN);
    next_s.init_go     = (next_s.state == ST_INIT);
    next_s.reset_hold  = any_reset | (next_s.state == ST_HOLD);

    // interrupts reach the controller only once running
    next_s.irq_req = next_s.release_cpu ? next_s.irq_flags : '0;
    // raw request while supply under the first threshold
    // a transient gone before release leaves no request
    next_s.bod_irq = next_s.release_cpu & s.filt[SYN_BOD_IRQ];

    next_s.rdata = 8'h00;
    if (reg_read) begin
      if (reg_addr == RATIO_ADDR) begin
        next_s.rdata = {6'h00, s.ratio};
      end else if (reg_addr == CAUSE_ADDR) begin
        next_s.rdata = {4'h0, s.flags};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s              <= '0;
      s.s1           <= SYNC_IDLE;
      s.s2           <= SYNC_IDLE;
      s.s3           <= SYNC_IDLE;
      s.filt         <= SYNC_IDLE;
      s.state        <= ST_HOLD;
      // power-on leaves only its own flag
      s.flags        <= CAUSE_RESET;
      s.ratio        <= RATIO_RESET;
      s.active_ratio <= RATIO_RESET;
      s.reset_hold   <= 1'b1;
    end else begin
      // sources still active after release set flags above
      s <= next_s;
    end
  end

  assign reg_rdata               = s.rdata;
  assign cpu_release             = s.release_cpu;
  assign chip_reset_hold         = s.reset_hold;
  assign init_start              = s.init_go;
  assign peripheral_clock_enable = s.pclk_en;
  assign pll_keep_on             = s.pll_keep;
  assign brownout_irq            = s.bod_irq;
  assign ext_irq_req             = s.irq_req;
  assign reset_cause_flags       = s.flags;

endmodule : reset_wakeup_clock_divider

// ---- verification/rwcd_sva.sv ----
// assertions on the ports of the reset, wakeup and clock divider block
module rwcd_sva #(
  parameter int WAKE_CLOCKS = 16
) (
  input wire logic                          clk,
  input wire logic                          reset_n,
  input wire logic                          ext_reset_pin_n,
  input wire logic                          brownout_below_2v9,
  input wire logic                          brownout_below_2v6,
  input wire logic                          watchdog_timeout,
  input wire logic                          watchdog_reset_enable,
  input wire logic                          power_down_request,
  input wire logic [31:0]                   reg_addr,
  input wire logic                          reg_read,
  input wire logic [7:0]                    reg_rdata,
  input wire logic                          cpu_release,
  input wire logic                          chip_reset_hold,
  input wire logic                          init_start,
  input wire logic                          brownout_irq,
  input wire logic [sysctl_pkg::FLAG_W-1:0] reset_cause_flags
);
  import sysctl_pkg::*;
  int gap;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles since the last reset hold, saturating so it cannot wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) gap <= 0;
    else gap <= chip_reset_hold ? 0 : gap + ((gap < 9999) ? 1 : 0);
  end
  a_ratio_legal: assert property (
    reg_read && reg_addr == RATIO_ADDR |=> reg_rdata[7:2] == 6'h0 && reg_rdata[1:0] != 2'h3)
    else $error("ratio reads a reserved value");
  a_ext_flag: assert property (
    !ext_reset_pin_n [*7] |-> reset_cause_flags[EXT_BIT] && !reset_cause_flags[WDT_BIT])
    else $error("external reset flag not set");
  a_wdt_flag: assert property (
    watchdog_timeout && watchdog_reset_enable |-> ##[1:3] reset_cause_flags[WDT_BIT])
    else $error("watchdog flag not set");
  a_bod_hold: assert property (
    brownout_below_2v6 [*7] |-> chip_reset_hold && !cpu_release && reset_cause_flags[BOD_BIT])
    else $error("brown-out reset not held");
  a_wake_gap: assert property (
    $rose(init_start) |-> gap > WAKE_CLOCKS)
    else $error("init started before the wakeup count");
  a_release_pin: assert property (
    $rose(cpu_release) |-> ext_reset_pin_n && $past(ext_reset_pin_n) && !init_start)
    else $error("release with reset pin low or init running");
  a_sleep_drop: assert property (
    cpu_release && power_down_request |=> !cpu_release)
    else $error("power down did not stop the processor");
  a_bod_irq: assert property (
    (brownout_below_2v9 && cpu_release) [*6] |-> brownout_irq)
    else $error("brown-out request missing");
  a_irq_quiet: assert property (
    !brownout_below_2v9 [*6] |-> !brownout_irq)
    else $error("brown-out request after supply recovered");
  c_release: cover property ($rose(cpu_release));
  c_bod_irq: cover property (brownout_irq);
  c_wdt: cover property (watchdog_timeout && watchdog_reset_enable);
endmodule : rwcd_sva

bind reset_wakeup_clock_divider rwcd_sva #(.WAKE_CLOCKS(WAKE_CLOCKS)) sva (
  .clk(clk), .reset_n(reset_n), .ext_reset_pin_n(ext_reset_pin_n),
  .brownout_below_2v9(brownout_below_2v9), .brownout_below_2v6(brownout_below_2v6),
  .watchdog_timeout(watchdog_timeout), .watchdog_reset_enable(watchdog_reset_enable),
  .power_down_request(power_down_request), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .cpu_release(cpu_release), .chip_reset_hold(chip_reset_hold),
  .init_start(init_start), .brownout_irq(brownout_irq),
  .reset_cause_flags(reset_cause_flags));

// ---- verification/core_model.sv ----
// far-side model: core finishing its init after a short or long latency
module core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic init_start,
  output logic     init_done
);
  int cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      init_done <= 1'b0;
    end else if (!init_start) begin
      cnt <= 0;
      init_done <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      init_done <= (cnt >= (slow ? 12 : 1));
    end
  end
endmodule : core_model

// ---- verification/test_reset_wakeup_clock_divider.sv ----
// self-checking bench for the reset, wakeup and clock divider block
module test_reset_wakeup_clock_divider;
  timeunit 1ns;
  timeprecision 1ns;
  import sysctl_pkg::*;
  localparam int W = 16;
  logic        clk, reset_n, pin_n, b29, b26, osc, bwen, wdt, wden, pdr;
  logic        idle, pll, idone, wr_s, rd_s, slow, rel, hold, istart, pce, keep, birq;
  logic [7:0]  pins, wdata, rdata, d, p;
  logic [3:0]  lvl, pol, wen, clr, ereq, flags;
  logic [31:0] addr;
  logic [7:0]  rexp [4] = '{8'h00, 8'h01, 8'h02, 8'h02};
  logic [7:0]  pexp [4] = '{8'h04, 8'h01, 8'h02, 8'h02};
  int          fails, check_count, n;

  reset_wakeup_clock_divider #(.WAKE_CLOCKS(W)) uut (
    .clk(clk), .reset_n(reset_n), .ext_reset_pin_n(pin_n), .brownout_below_2v9(b29),
    .brownout_below_2v6(b26), .osc_detected(osc), .ext_irq_pins(pins),
    .ext_irq_level_mode(lvl), .ext_irq_polarity(pol), .ext_irq_wake_enable(wen),
    .ext_irq_clear(clr), .brownout_wake_enable(bwen), .watchdog_timeout(wdt),
    .watchdog_reset_enable(wden), .power_down_request(pdr), .idle_mode(idle),
    .pll_running(pll), .init_done(idone), .reg_addr(addr), .reg_write(wr_s),
    .reg_read(rd_s), .reg_wdata(wdata), .reg_rdata(rdata), .cpu_release(rel),
    .chip_reset_hold(hold), .init_start(istart), .peripheral_clock_enable(pce),
    .pll_keep_on(keep), .brownout_irq(birq), .ext_irq_req(ereq), .reset_cause_flags(flags));
  core_model far (.clk(clk), .reset_n(reset_n), .slow(slow), .init_start(istart),
    .init_done(idone));

  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(string what, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr(logic [31:0] a, logic [7:0] v);
    addr = a;
    wdata = v;
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(logic [31:0] a, output logic [7:0] v);
    addr = a;
    rd_s = 1'b1;
    tick(1);
    v = rdata;
    rd_s = 1'b0;
    tick(1);
  endtask : rd
  task automatic wait_run();
    int i;
    for (i = 0; i < 300 && rel !== 1'b1; i++) tick(1);
    chk("release", 8'h01, {7'h0, rel});
  endtask : wait_run
  // cycles between two peripheral clock enables
  task automatic per(output logic [7:0] q);
    int i;
    for (i = 0; i < 9 && pce !== 1'b1; i++) tick(1);
    q = 8'h0;
    do begin
      tick(1);
      q++;
    end while (pce !== 1'b1 && q < 8'h9);
  endtask : per
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    {reset_n, pin_n, b29, b26, osc, bwen, wdt, wden, pdr, idle, wr_s, rd_s, slow} = 13'h0;
    {pll, pins, lvl, pol, wen, clr, addr, wdata} = {1'b1, 8'hff, 4'h1, 4'h0, 4'h1, 4'h0,
      32'h0, 8'h0};
    tick(20);
    reset_n = 1'b1;
    tick(5);
    pin_n = 1'b1;
    tick(10);
    osc = 1'b1;
    n = 0;
    while (istart !== 1'b1 && n < 99) begin
      tick(1);
      n++;
    end
    chk("wake count", 8'h01, {7'h0, n >= W && n <= W + 6});
    wait_run();
    rd(CAUSE_ADDR, d);
    chk("cause", 8'h03, d);
    wr(CAUSE_ADDR, 8'h02);
    rd(CAUSE_ADDR, d);
    chk("cause", 8'h01, d);
    rd(32'he01fc104, d);
    chk("unmapped", 8'h00, d);
    rd(RATIO_ADDR, d);
    chk("ratio", 8'h00, d);
    per(p);
    chk("period", 8'h04, p);
    for (int k = 0; k < 4; k++) begin
      wr(RATIO_ADDR, k[7:0]);
      tick(10);
      rd(RATIO_ADDR, d);
      chk("ratio", rexp[k], d);
      per(p);
      chk("period", pexp[k], p);
    end
    $display("test divider done");
    wr(CAUSE_ADDR, 8'h0f);
    slow = 1'b1;
    pin_n = 1'b0;
    tick(8);
    pin_n = 1'b1;
    wait_run();
    rd(CAUSE_ADDR, d);
    chk("cause", 8'h02, d);
    wdt = 1'b1;
    tick(1);
    wdt = 1'b0;
    tick(5);
    chk("release", 8'h01, {7'h0, rel});
    {wden, wdt} = 2'h3;
    tick(1);
    wdt = 1'b0;
    tick(2);
    wait_run();
    rd(CAUSE_ADDR, d);
    chk("cause", 8'h06, d);
    {b26, b29} = 2'h3;
    tick(10);
    {b26, b29} = 2'h0;
    tick(2);
    wait_run();
    rd(CAUSE_ADDR, d);
    chk("cause", 8'h0a, d);
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    wait_run();
    rd(CAUSE_ADDR, d);
    chk("cause", 8'h01, d);
    rd(RATIO_ADDR, d);
    chk("ratio", 8'h00, d);
    wr(CAUSE_ADDR, 8'h0f);
    $display("test reset causes done");
    b29 = 1'b1;
    tick(8);
    chk("bod irq", 8'h01, {7'h0, birq});
    b29 = 1'b0;
    tick(8);
    chk("bod irq", 8'h00, {7'h0, birq});
    pdr = 1'b1; // pin mode, polarity and wake enable set before
    tick(1);
    pdr = 1'b0;
    tick(3);
    chk("sleep", 8'h00, {7'h0, rel});
    pins = 8'hfd;
    tick(4);
    pins = 8'hff;
    chk("irq early", 8'h00, {4'h0, ereq});
    wait_run();
    chk("irq", 8'h01, {4'h0, ereq});
    clr = 4'h1;
    tick(1);
    clr = 4'h0;
    tick(2);
    chk("irq", 8'h00, {4'h0, ereq});
    pins = 8'hf7;
    tick(8);
    chk("edge irq", 8'h00, {4'h0, ereq});
    pins = 8'hfb;
    tick(8);
    chk("edge irq", 8'h02, {4'h0, ereq});
    {pins, clr} = {8'hff, 4'h2};
    tick(1);
    clr = 4'h0;
    tick(8);
    chk("edge irq", 8'h00, {4'h0, ereq});
    $display("test wakeup done");
    {bwen, pdr} = 2'h3;
    tick(1);
    pdr = 1'b0;
    tick(3);
    b29 = 1'b1;
    tick(4);
    b29 = 1'b0;
    wait_run();
    tick(4);
    chk("bod irq", 8'h00, {7'h0, birq});
    rd(CAUSE_ADDR, d);
    chk("cause", 8'h00, d);
    idle = 1'b1;
    tick(2);
    pll = 1'b0;
    tick(3);
    chk("pll keep", 8'h01, {7'h0, keep});
    idle = 1'b0;
    tick(2);
    chk("pll keep", 8'h00, {7'h0, keep});
    $display("test brown-out and idle done");
    give_verdict();
  end
endmodule : test_reset_wakeup_clock_divider
